// ==== hw/tsh_map.vh ====
/*
 * Register map, field positions, reset values and timing counts for the
 * temperature smoothing and hold block.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef TSH_MAP_VH
`define TSH_MAP_VH

// Byte offsets on the AXI4-Lite bus
`define TSH_ADDR_CTRL 8'h00
`define TSH_ADDR_AVG 8'h04
`define TSH_ADDR_HOLD 8'h08
`define TSH_ADDR_THR 8'h0C
`define TSH_ADDR_AMB 8'h10
`define TSH_ADDR_EMIS 8'h14
`define TSH_ADDR_TRANS 8'h18
`define TSH_ADDR_TARG 8'h1C
`define TSH_ADDR_LED 8'h20
`define TSH_ADDR_STAT 8'h24
`define TSH_ADDR_STAT2 8'h28

// Control fields
`define TSH_CTRL_UNIT 0
`define TSH_CTRL_AMBFIX 1
`define TSH_CTRL_AVG_LO 2
`define TSH_CTRL_AVG_HI 3
`define TSH_CTRL_HOLD_LO 4
`define TSH_CTRL_HOLD_HI 6
`define TSH_CTRL_LED_LO 7
`define TSH_CTRL_LED_HI 8
`define TSH_CTRL_HYST 9
`define TSH_CTRL_CALC 10

// Mode encodings
`define TSH_AVG_OFF 2'h0
`define TSH_AVG_NORM 2'h1
`define TSH_AVG_HYST 2'h2
`define TSH_HOLD_OFF 3'h0
`define TSH_HOLD_MIN 3'h1
`define TSH_HOLD_MAX 3'h2
`define TSH_HOLD_EMIN 3'h3
`define TSH_HOLD_EMAX 3'h4
`define TSH_LED_OFF 2'h0
`define TSH_LED_MIN 2'h1
`define TSH_LED_MAX 2'h2

// Reset values; gains are Q10, 1.0 = 0x400
`define TSH_RST_GAIN 32'h0000_0400
`define TSH_RST_ZERO 32'h0000_0000
`define TSH_GAIN_SHIFT 10
`define TSH_AVG_MAXSH 4'h8

// Fahrenheit scaling of tenths of a degree: 9/5 in Q10 plus 32.0
`define TSH_F_MUL 32'h0000_0733
`define TSH_F_OFS 32'h0000_0140

// Timing: hold and reset times count in 1 ms ticks
`define TSH_TICK_NS 1000000
`define TSH_CLK_NS 20
`define TSH_TICK_CYC (`TSH_TICK_NS / `TSH_CLK_NS)

// AXI responses
`define TSH_RESP_OKAY 2'h0
`define TSH_RESP_SLVERR 2'h2

`endif

// ==== hw/tsh_top.v ====
/*
 * Temperature post-processing: ambient and gain compensation, averaging,
 * min/max hold, unit conversion, alignment LED and emissivity calculation.
 * Assumes samples and head probe values come from logic on aclk as signed
 * tenths of a degree Celsius, and an AXI4-Lite master on the same clock.
 */
// Chosen here: register access over AXI4-Lite and the placing of the registers.
// Behaviour
// - Normal averaging outputs the arithmetic mean over the configured window.
// - Hysteresis averaging forwards a rising sample exceeding mean plus hysteresis.
// - Exactly one hold algorithm runs, or none when disabled.
// - Maximum search holds the previous peak for the hold time on falls.
// - Minimum search holds the previous low for the hold time on rises.
// - Until the hold time expires, extended maximum accepts a lower peak only after input fell below threshold.
// - With hysteresis, a lower peak also needs a drop by the hysteresis.
// - Until the hold time expires, extended minimum accepts a higher low only after input rose above threshold.
// - With hysteresis, a higher minimum also needs a rise by the hysteresis.
// - Automatic ambient mode takes ambient from the head probe.
// - Fixed ambient mode uses the host constant and ignores the probe.
// - Outputs are expressed in Celsius or Fahrenheit per the unit setting.
// - A transmissivity gain compensates window or lens attenuation.
// - Calculate command derives emissivity matching the host target temperature.
// - Alignment aid drives the green LED in minimum or maximum search.
// - Both process temperature and averaged-only temperature are provided.
`timescale 1ns/1ps
`include "tsh_map.vh"

module tsh_top #(
    parameter TICK_CYC = `TSH_TICK_CYC
)
(
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire sample_valid,
    input wire [15:0] sample_data,
    input wire [15:0] head_temp,
    output wire [15:0] proc_temp,
    output wire [15:0] avg_temp,
    output wire temp_valid,
    output wire led_green
);

    localparam DIV_IDLE = 1'b0;
    localparam DIV_RUN = 1'b1;

    reg aw_free_reg, w_free_reg, bvalid_reg, rvalid_reg, ar_free_reg;
    reg [1:0] bresp_reg, rresp_reg;
    reg [31:0] rdata_reg;
    reg [7:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg [31:0] ctrl_reg, avgc_reg, holdt_reg, thr_reg, amb_reg;
    reg [31:0] emis_reg, trans_reg, targ_reg, ledc_reg;
    reg cfg_chg_reg, calc_go_reg;
    reg div_state_reg, div_done_reg, div_busy_reg;
    reg [31:0] num_reg, den_reg, quo_reg;
    reg [32:0] rem_reg;
    reg [4:0] dcnt_reg;
    reg [16:0] tick_cnt_reg;
    reg tick_reg;
    reg a_vld_reg, b_vld_reg, c_vld_reg, out_vld_reg;
    reg [15:0] comp_reg, avg_reg, held_reg, ambu_reg, proc_reg, avgo_reg;
    reg [16:0] dlast_reg;
    reg [15:0] abuf [0:255];
    reg [7:0] wptr_reg;
    reg [8:0] fill_reg;
    reg [23:0] sum_reg;
    reg [15:0] htmr_reg, ltmr_reg;
    reg armed_reg, led_reg;
    reg [15:0] lext_reg;

    wire [1:0] avg_mode = ctrl_reg[`TSH_CTRL_AVG_HI:`TSH_CTRL_AVG_LO];
    wire [2:0] hold_mode = ctrl_reg[`TSH_CTRL_HOLD_HI:`TSH_CTRL_HOLD_LO];
    wire [1:0] led_mode = ctrl_reg[`TSH_CTRL_LED_HI:`TSH_CTRL_LED_LO];
    wire do_wr = !aw_free_reg && !w_free_reg && !bvalid_reg;

    // Byte-lane merge for partial writes
    function [31:0] tsh_merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0] st;
        integer i;
        begin
            tsh_merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (st[i])
                    tsh_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
    endfunction

    // Celsius tenths to selected unit
    function [15:0] tsh_unit;
        input [15:0] c;
        input f_sel;
        reg signed [31:0] p;
        begin
            p = $signed({{16{c[15]}}, c}) * $signed(`TSH_F_MUL);
            p = (p >>> `TSH_GAIN_SHIFT) + $signed(`TSH_F_OFS);
            tsh_unit = f_sel ? p[15:0] : c;
        end
    endfunction

    // AXI write channels: address and data taken in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_free_reg <= 1'b1;
            w_free_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `TSH_RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && aw_free_reg)
            begin
                aw_free_reg <= 1'b0;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && w_free_reg)
            begin
                w_free_reg <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_free_reg <= 1'b1;
                w_free_reg <= 1'b1;
                bvalid_reg <= 1'b1;
                bresp_reg <= (awaddr_reg > `TSH_ADDR_LED ||
                    awaddr_reg[1:0] != 2'h0) ?
                    `TSH_RESP_SLVERR : `TSH_RESP_OKAY;
            end
            else if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    // Configuration registers; the divider result loads emissivity, a host write in the same cycle wins
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg <= `TSH_RST_ZERO;
            avgc_reg <= `TSH_RST_ZERO;
            holdt_reg <= `TSH_RST_ZERO;
            thr_reg <= `TSH_RST_ZERO;
            amb_reg <= `TSH_RST_ZERO;
            emis_reg <= `TSH_RST_GAIN;
            trans_reg <= `TSH_RST_GAIN;
            targ_reg <= `TSH_RST_ZERO;
            ledc_reg <= `TSH_RST_ZERO;
            cfg_chg_reg <= 1'b0;
            calc_go_reg <= 1'b0;
        end
        else
        begin
            cfg_chg_reg <= 1'b0;
            calc_go_reg <= 1'b0;
            if (div_done_reg)
                emis_reg <= quo_reg;
            if (do_wr)
            begin
                if (awaddr_reg == `TSH_ADDR_CTRL)
                begin
                    ctrl_reg <= tsh_merge(ctrl_reg, wdata_reg, wstrb_reg)
                        & 32'h0000_03FF;
                    calc_go_reg <= wdata_reg[`TSH_CTRL_CALC] &&
                        wstrb_reg[1];
                    cfg_chg_reg <= 1'b1;
                end
                else if (awaddr_reg == `TSH_ADDR_AVG)
                begin
                    avgc_reg <= tsh_merge(avgc_reg, wdata_reg, wstrb_reg);
                    cfg_chg_reg <= 1'b1;
                end
                else if (awaddr_reg == `TSH_ADDR_HOLD)
                    holdt_reg <= tsh_merge(holdt_reg, wdata_reg, wstrb_reg);
                else if (awaddr_reg == `TSH_ADDR_THR)
                    thr_reg <= tsh_merge(thr_reg, wdata_reg, wstrb_reg);
                else if (awaddr_reg == `TSH_ADDR_AMB)
                    amb_reg <= tsh_merge(amb_reg, wdata_reg, wstrb_reg);
                else if (awaddr_reg == `TSH_ADDR_EMIS)
                    emis_reg <= tsh_merge(emis_reg, wdata_reg, wstrb_reg);
                else if (awaddr_reg == `TSH_ADDR_TRANS)
                    trans_reg <= tsh_merge(trans_reg, wdata_reg, wstrb_reg);
                else if (awaddr_reg == `TSH_ADDR_TARG)
                    targ_reg <= tsh_merge(targ_reg, wdata_reg, wstrb_reg);
                else if (awaddr_reg == `TSH_ADDR_LED)
                    ledc_reg <= tsh_merge(ledc_reg, wdata_reg, wstrb_reg);
            end
        end
    end

    // AXI read channel: one-cycle answer, unmapped reads give SLVERR
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            ar_free_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `TSH_RESP_OKAY;
        end
        else if (s_axi_arvalid && ar_free_reg)
        begin
            rvalid_reg <= 1'b1;
            ar_free_reg <= 1'b0;
            rresp_reg <= `TSH_RESP_OKAY;
            if (s_axi_araddr == `TSH_ADDR_CTRL)
                rdata_reg <= ctrl_reg;
            else if (s_axi_araddr == `TSH_ADDR_AVG)
                rdata_reg <= avgc_reg;
            else if (s_axi_araddr == `TSH_ADDR_HOLD)
                rdata_reg <= holdt_reg;
            else if (s_axi_araddr == `TSH_ADDR_THR)
                rdata_reg <= thr_reg;
            else if (s_axi_araddr == `TSH_ADDR_AMB)
                rdata_reg <= amb_reg;
            else if (s_axi_araddr == `TSH_ADDR_EMIS)
                rdata_reg <= emis_reg;
            else if (s_axi_araddr == `TSH_ADDR_TRANS)
                rdata_reg <= trans_reg;
            else if (s_axi_araddr == `TSH_ADDR_TARG)
                rdata_reg <= targ_reg;
            else if (s_axi_araddr == `TSH_ADDR_LED)
                rdata_reg <= ledc_reg;
            else if (s_axi_araddr == `TSH_ADDR_STAT)
                rdata_reg <= {avgo_reg, proc_reg};
            else if (s_axi_araddr == `TSH_ADDR_STAT2)
                rdata_reg <= {15'h0000, div_busy_reg, ambu_reg};
            else
            begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= `TSH_RESP_SLVERR;
            end
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
            ar_free_reg <= 1'b1;
        end
    end

    // 1 ms tick for hold and LED reset timers
    always @(posedge aclk)
    begin
        if (!aresetn || tick_cnt_reg == TICK_CYC[16:0] - 17'h0_0001)
            tick_cnt_reg <= 17'h0_0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 17'h0_0001;
        tick_reg <= aresetn &&
            (tick_cnt_reg == TICK_CYC[16:0] - 17'h0_0001);
    end

    // Stage A: ambient choice, emissivity and transmissivity gains
    wire [15:0] amb_use = ctrl_reg[`TSH_CTRL_AMBFIX] ?
        amb_reg[15:0] : head_temp;
    wire signed [16:0] d_s = $signed({sample_data[15], sample_data}) -
        $signed({amb_use[15], amb_use});
    wire signed [33:0] m1 = d_s * $signed({1'b0, emis_reg[15:0]});
    wire signed [40:0] m2 = $signed(m1[33:10]) *
        $signed({1'b0, trans_reg[15:0]});
    wire [15:0] comp_next = m2[25:10] + amb_use;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            a_vld_reg <= 1'b0;
            comp_reg <= 16'h0000;
            ambu_reg <= 16'h0000;
            dlast_reg <= 17'h0_0000;
        end
        else
        begin
            a_vld_reg <= sample_valid;
            if (sample_valid)
            begin
                comp_reg <= comp_next;
                ambu_reg <= amb_use;
                dlast_reg <= d_s;
            end
        end
    end

    // Stage B: boxcar mean over 2^n samples kept in a ring buffer.
    // Power-of-two windows trade averaging-time resolution for no divider.
    wire [3:0] ash = (avgc_reg[3:0] > `TSH_AVG_MAXSH) ?
        `TSH_AVG_MAXSH : avgc_reg[3:0];
    wire [8:0] alen = 9'h001 << ash;
    wire [7:0] optr = wptr_reg - alen[7:0];
    wire [15:0] old_s = abuf[optr];
    wire full = (fill_reg == alen);
    wire [23:0] sum_next = full ?
        sum_reg + {{8{comp_reg[15]}}, comp_reg} -
        {{8{old_s[15]}}, old_s} :
        sum_reg + {{8{comp_reg[15]}}, comp_reg};
    wire [23:0] mean_w = $signed(sum_next) >>> ash;
    wire signed [16:0] hlim = $signed({mean_w[15], mean_w[15:0]}) +
        $signed({1'b0, avgc_reg[31:16]});
    wire fast_rise = $signed({comp_reg[15], comp_reg}) > hlim;

    always @(posedge aclk)
    begin
        if (sample_valid || a_vld_reg)
            abuf[wptr_reg] <= a_vld_reg ? comp_reg : abuf[wptr_reg];
        if (!aresetn || cfg_chg_reg)
        begin
            wptr_reg <= 8'h00;
            fill_reg <= 9'h000;
            sum_reg <= 24'h00_0000;
            b_vld_reg <= 1'b0;
            avg_reg <= aresetn ? avg_reg : 16'h0000;
        end
        else
        begin
            b_vld_reg <= a_vld_reg;
            if (a_vld_reg)
            begin
                wptr_reg <= wptr_reg + 8'h01;
                sum_reg <= sum_next;
                if (!full)
                    fill_reg <= fill_reg + 9'h001;
                if (avg_mode == `TSH_AVG_OFF)
                    avg_reg <= comp_reg;
                else if (avg_mode == `TSH_AVG_HYST && fast_rise)
                    avg_reg <= comp_reg;
                else
                    avg_reg <= mean_w[15:0];
            end
        end
    end

    // Stage C: hold algorithms on the averaged value
    wire signed [16:0] x_s = $signed({avg_reg[15], avg_reg});
    wire signed [16:0] h_s = $signed({held_reg[15], held_reg});
    wire signed [16:0] t_s = $signed({thr_reg[15], thr_reg[15:0]});
    wire signed [16:0] hy_s = $signed({1'b0, thr_reg[31:16]});
    wire hen = ctrl_reg[`TSH_CTRL_HYST];
    wire h_exp = (htmr_reg == 16'h0000);
    wire is_min = (hold_mode == `TSH_HOLD_MIN) ||
        (hold_mode == `TSH_HOLD_EMIN);
    wire [15:0] h_time = is_min ? holdt_reg[15:0] : holdt_reg[31:16];
    reg adopt, arm_clr;

    // Adoption decision, one algorithm at a time
    always @*
    begin
        adopt = 1'b1;
        arm_clr = 1'b0;
        case (hold_mode)
            `TSH_HOLD_MIN: adopt = (x_s <= h_s) || h_exp;
            `TSH_HOLD_MAX: adopt = (x_s >= h_s) || h_exp;
            `TSH_HOLD_EMIN:
            begin
                arm_clr = armed_reg && (!hen || x_s >= h_s + hy_s);
                adopt = (x_s <= h_s) || h_exp || arm_clr;
            end
            `TSH_HOLD_EMAX:
            begin
                arm_clr = armed_reg && (!hen || x_s <= h_s - hy_s);
                adopt = (x_s >= h_s) || h_exp || arm_clr;
            end
            default: adopt = 1'b1;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn || cfg_chg_reg)
        begin
            c_vld_reg <= 1'b0;
            htmr_reg <= 16'h0000;
            armed_reg <= 1'b0;
            held_reg <= aresetn ? held_reg : 16'h0000;
        end
        else
        begin
            c_vld_reg <= b_vld_reg;
            if (tick_reg && !h_exp)
                htmr_reg <= htmr_reg - 16'h0001;
            if (b_vld_reg)
            begin
                if ((hold_mode == `TSH_HOLD_EMIN && x_s > t_s) ||
                    (hold_mode == `TSH_HOLD_EMAX && x_s < t_s))
                    armed_reg <= 1'b1;
                else if (arm_clr)
                    armed_reg <= 1'b0;
                if (adopt)
                begin
                    held_reg <= avg_reg;
                    htmr_reg <= h_time;
                end
            end
        end
    end

    // Alignment aid: LED lit while within hysteresis of the tracked extreme
    wire [15:0] pv = held_reg;
    wire signed [16:0] p_s = $signed({pv[15], pv});
    wire signed [16:0] e_s = $signed({lext_reg[15], lext_reg});
    wire signed [16:0] lhy = $signed({1'b0, ledc_reg[15:0]});
    wire l_exp = (ltmr_reg == 16'h0000);
    wire l_new = l_exp || (led_mode == `TSH_LED_MIN ? p_s < e_s : p_s > e_s);

    always @(posedge aclk)
    begin
        if (!aresetn || led_mode == `TSH_LED_OFF)
        begin
            led_reg <= 1'b0;
            ltmr_reg <= 16'h0000;
            lext_reg <= 16'h0000;
        end
        else
        begin
            if (tick_reg && !l_exp)
                ltmr_reg <= ltmr_reg - 16'h0001;
            if (c_vld_reg)
            begin
                if (l_new)
                begin
                    lext_reg <= pv;
                    ltmr_reg <= ledc_reg[31:16];
                end
                led_reg <= l_new || (led_mode == `TSH_LED_MIN ?
                    p_s <= e_s + lhy : p_s >= e_s - lhy);
            end
        end
    end

    // Output stage in the selected unit
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_vld_reg <= 1'b0;
            proc_reg <= 16'h0000;
            avgo_reg <= 16'h0000;
        end
        else
        begin
            out_vld_reg <= c_vld_reg;
            if (c_vld_reg)
            begin
                proc_reg <= tsh_unit(held_reg, ctrl_reg[`TSH_CTRL_UNIT]);
                avgo_reg <= tsh_unit(avg_reg, ctrl_reg[`TSH_CTRL_UNIT]);
            end
        end
    end

    // Emissivity calculation: restoring divide, one quotient bit per cycle.
    // Needs target above ambient and a last sample above ambient.
    wire signed [33:0] dn = $signed(dlast_reg) *
        $signed({1'b0, trans_reg[15:0]});
    wire signed [16:0] tn = $signed({targ_reg[15], targ_reg[15:0]}) -
        $signed({ambu_reg[15], ambu_reg});
    wire [32:0] rsh = {rem_reg[31:0], num_reg[31]};

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_state_reg <= DIV_IDLE;
            div_done_reg <= 1'b0;
            div_busy_reg <= 1'b0;
            num_reg <= 32'h0000_0000;
            den_reg <= 32'h0000_0000;
            quo_reg <= 32'h0000_0000;
            rem_reg <= 33'h0_0000_0000;
            dcnt_reg <= 5'h00;
        end
        else
        begin
            div_done_reg <= 1'b0;
            case (div_state_reg)
                DIV_IDLE:
                    if (calc_go_reg && tn > 0 && $signed(dn[33:10]) > 0)
                    begin
                        num_reg <= {5'h00, tn[16:0], 10'h000};
                        den_reg <= {8'h00, dn[33:10]};
                        rem_reg <= 33'h0_0000_0000;
                        dcnt_reg <= 5'h1F;
                        div_busy_reg <= 1'b1;
                        div_state_reg <= DIV_RUN;
                    end
                default:
                begin
                    num_reg <= {num_reg[30:0], 1'b0};
                    if (rsh >= {1'b0, den_reg})
                    begin
                        rem_reg <= rsh - {1'b0, den_reg};
                        quo_reg <= {quo_reg[30:0], 1'b1};
                    end
                    else
                    begin
                        rem_reg <= rsh;
                        quo_reg <= {quo_reg[30:0], 1'b0};
                    end
                    dcnt_reg <= dcnt_reg - 5'h01;
                    if (dcnt_reg == 5'h00)
                    begin
                        div_done_reg <= 1'b1;
                        div_busy_reg <= 1'b0;
                        div_state_reg <= DIV_IDLE;
                    end
                end
            endcase
        end
    end

    assign s_axi_awready = aw_free_reg;
    assign s_axi_wready = w_free_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ar_free_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign proc_temp = proc_reg;
    assign avg_temp = avgo_reg;
    assign temp_valid = out_vld_reg;
    assign led_green = led_reg;

endmodule // tsh_top

// ==== test/tsh_checker.sv ====
/* Assertions on the bus answers and sample timing of tsh_top.
   Assumes it is bound into tsh_top and sees only its ports. */
`timescale 1ns/1ps
module tsh_checker (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire sample_valid,
    input wire temp_valid,
    input wire [15:0] proc_temp
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A response stands until the master takes it
    chk_b_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_ar_busy: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    chk_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // Both halves of a write must be taken before its response
    chk_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    chk_b_cause: assert property (
        $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("response without a taken write");
    // Four-stage pipeline from sample to outputs
    chk_tv_latency: assert property (
        sample_valid |-> ##4 temp_valid) else $error("output not after 4");
    chk_tv_cause: assert property (
        temp_valid |-> $past(sample_valid, 4)) else $error("stray output");
    chk_proc_quiet: assert property (
        $changed(proc_temp) |-> temp_valid) else $error("output moved alone");
endmodule // tsh_checker

// ==== test/tsh_source.sv ====
/* Detector sample source: one sample pulse for each go pulse.
   Assumes go is driven just after a rising edge of aclk. */
`timescale 1ns/1ps
module tsh_source (
    input wire aclk,
    input wire go,
    input wire [15:0] s,
    input wire [15:0] h,
    output logic sample_valid = 1'b0,
    output logic [15:0] sample_data = 16'h0000,
    output logic [15:0] head_temp = 16'h0000
);
    // Lines toggle between samples so a stale value is never trusted
    always @(posedge aclk)
    begin
        sample_valid <= go;
        sample_data <= go ? s : ~sample_data;
        head_temp <= go ? h : ~head_temp;
    end
endmodule // tsh_source

// ==== test/temperature_smoothing_hold_bench.sv ====
/* Self-checking bench for tsh_top with a sample source model.
   Assumes tsh_map.vh on the include path and a 50 MHz clock. */
`timescale 1ns/1ps
`include "tsh_map.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    bad_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module temperature_smoothing_hold_bench;
    typedef struct {logic [15:0] c, p, s, h, e;} tsh_row_t;
    logic aclk = 0, aresetn = 0, go = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [15:0] ps = '0, ph = '0, sd, ht, proc, avg;
    logic [1:0] bresp, rresp, r;
    logic awrdy, wrdy, bvalid, arrdy, rvalid, sv, tv, led;
    int bad_count = 0, samples_checked = 0, i;
    // Control, priming sample, sample, head value, expected output
    tsh_row_t rows [9] = '{
        '{16'h0000, 16'h0000, 16'h0064, 16'h0028, 16'h0118},
        '{16'h0002, 16'h0000, 16'h0064, 16'h0028, 16'h0190},
        '{16'h0001, 16'h0000, 16'h0064, 16'h0064, 16'h01F3},
        '{16'h0020, 16'h01F4, 16'h012C, 16'h012C, 16'h01F4},
        '{16'h0010, 16'h012C, 16'h01F4, 16'h01F4, 16'h012C},
        '{16'h0004, 16'h0064, 16'h012C, 16'h012C, 16'h00C8},
        '{16'h0008, 16'h0064, 16'h012C, 16'h012C, 16'h012C},
        '{16'h0040, 16'h05DC, 16'h0514, 16'h0514, 16'h05DC},
        '{16'h00B0, 16'h012C, 16'h01F4, 16'h01F4, 16'h012C}};
    initial forever #10 aclk = ~aclk;
    // Short tick so hold times stay within a few hundred cycles
    tsh_top #(.TICK_CYC(10)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sample_valid(sv),
        .sample_data(sd), .head_temp(ht), .proc_temp(proc),
        .avg_temp(avg), .temp_valid(tv), .led_green(led));
    tsh_source src_u (.aclk(aclk), .go(go), .s(ps), .h(ph),
        .sample_valid(sv), .sample_data(sd), .head_temp(ht));
    task give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task stop_hung;
        bad_count++;
        give_verdict;
    endtask
    // Each channel is released only at the edge that takes it
    task automatic wr(input [7:0] a, input [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        repeat (50)
        begin
            @(posedge aclk);
            if (awrdy) awvalid <= 0;
            if (wrdy) wvalid <= 0;
            if (bvalid) break;
        end
        if (bvalid !== 1'b1) stop_hung;
        r = bresp;
        bready <= 0;
    endtask
    task automatic rd(input [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        repeat (50)
        begin
            @(posedge aclk);
            if (arrdy) arvalid <= 0;
            if (rvalid) break;
        end
        if (rvalid !== 1'b1) stop_hung;
        d = rdata;
        rready <= 0;
    endtask
    // One sample through the source, then wait for the output pulse
    task automatic snd(input [15:0] s, input [15:0] h);
        @(posedge aclk);
        ps <= s;
        ph <= h;
        go <= 1;
        @(posedge aclk);
        go <= 0;
        repeat (20)
        begin
            @(posedge aclk);
            if (tv) break;
        end
        if (tv !== 1'b1) stop_hung;
    endtask
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        rd(`TSH_ADDR_CTRL);
        `CHK("ctrl", 32'h0000_0000, d)
        rd(`TSH_ADDR_EMIS);
        `CHK("emis", `TSH_RST_GAIN, d)
        wr(`TSH_ADDR_STAT, 32'h0000_0001);
        `CHK("ro_resp", `TSH_RESP_SLVERR, r)
        wr(`TSH_ADDR_EMIS, 32'h0000_0800);
        wr(`TSH_ADDR_TRANS, 32'h0000_0800);
        wr(`TSH_ADDR_AVG, 32'h0000_0001);
        wr(`TSH_ADDR_HOLD, 32'h0005_0005);
        wr(`TSH_ADDR_THR, 32'h0000_03E8);
        for (i = 0; i < 9; i++)
        begin
            wr(`TSH_ADDR_CTRL, {16'h0000, rows[i].c});
            snd(rows[i].p, rows[i].p);
            snd(rows[i].s, rows[i].h);
            `CHK("proc", rows[i].e, proc)
        end
        `CHK("avg", 16'h01F4, avg)
        `CHK("led", 1'b1, led)
        rd(`TSH_ADDR_STAT);
        `CHK("stat", 32'h01F4_012C, d)
        `CHK("rresp", `TSH_RESP_OKAY, rresp)
        give_verdict;
    end
endmodule // temperature_smoothing_hold_bench
bind tsh_top tsh_checker chk_u (.*);
